// file: design/pieme_top.sv
// peripheral interrupt enable mask register and request gating
`timescale 1ns/1ns
module pieme_top
    import pieme_pkg::*;
(
    // clock and reset
    input  wire logic       ref_clk_i,
    input  wire logic       rstn_i,
    // register bus
    input  wire logic [7:0] reg_addr_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    input  wire logic [7:0] reg_wdata_i,
    output logic      [7:0] reg_rdata_o,
    // peripheral flags
    input  wire logic       cmp1_rise_flag_i,
    input  wire logic       cmp1_fall_flag_i,
    input  wire logic       cmp0_rise_flag_i,
    input  wire logic       cmp0_fall_flag_i,
    input  wire logic [4:0] counter_array_flag_i,
    input  wire logic       converter_window_flag_i,
    input  wire logic       smbus_port_flag_i,
    input  wire logic       spi_port_flag_i,
    // gated requests to the core and the mask value
    output logic [PIEME_NUM_SRC-1:0] irq_req_o,
    output logic [7:0]               mask_o
);
    logic [7:0]               mask_d;
    logic [7:0]               mask_q;
    logic [7:0]               rdata_d;
    logic [7:0]               rdata_q;
    logic [PIEME_NUM_SRC-1:0] flags;
    logic [PIEME_NUM_SRC-1:0] en;

    // register decode
    wire sel_mask = (reg_addr_i == PIEME_MASK_ADDR);
    wire wr_mask  = sel_mask & reg_wr_i;
    wire rd_mask  = sel_mask & reg_rd_i;

    // mask write and read decode, a read in the same cycle as a write returns the old mask
    assign mask_d  = wr_mask ? reg_wdata_i : mask_q;
    assign rdata_d = rd_mask ? mask_q : 8'h00;

    // named enable fields of the mask
    wire cmp1_rise_irq_en        = mask_q[PIEME_CMP1_RISE];
    wire cmp1_fall_irq_en        = mask_q[PIEME_CMP1_FALL];
    wire cmp0_rise_irq_en        = mask_q[PIEME_CMP0_RISE];
    wire cmp0_fall_irq_en        = mask_q[PIEME_CMP0_FALL];
    wire counter_array_irq_en    = mask_q[PIEME_CNT_ARRAY];
    wire converter_window_irq_en = mask_q[PIEME_CONV_WIN];
    wire smbus_port_irq_en       = mask_q[PIEME_SMBUS_PORT];
    wire spi_port_irq_en         = mask_q[PIEME_SPI_PORT];

    // enables in mask bit order
    assign en[PIEME_CMP1_RISE]  = cmp1_rise_irq_en;
    assign en[PIEME_CMP1_FALL]  = cmp1_fall_irq_en;
    assign en[PIEME_CMP0_RISE]  = cmp0_rise_irq_en;
    assign en[PIEME_CMP0_FALL]  = cmp0_fall_irq_en;
    assign en[PIEME_CNT_ARRAY]  = counter_array_irq_en;
    assign en[PIEME_CONV_WIN]   = converter_window_irq_en;
    assign en[PIEME_SMBUS_PORT] = smbus_port_irq_en;
    assign en[PIEME_SPI_PORT]   = spi_port_irq_en;

    // source order follows the mask bit order
    assign flags[PIEME_CMP1_RISE]  = cmp1_rise_flag_i;
    assign flags[PIEME_CMP1_FALL]  = cmp1_fall_flag_i;
    assign flags[PIEME_CMP0_RISE]  = cmp0_rise_flag_i;
    assign flags[PIEME_CMP0_FALL]  = cmp0_fall_flag_i;
    assign flags[PIEME_CNT_ARRAY]  = |counter_array_flag_i;
    assign flags[PIEME_CONV_WIN]   = converter_window_flag_i;
    assign flags[PIEME_SMBUS_PORT] = smbus_port_flag_i;
    assign flags[PIEME_SPI_PORT]   = spi_port_flag_i;

    // mask and read data registers
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            mask_q  <= PIEME_MASK_RESET;
            rdata_q <= 8'h00;
        end else begin
            mask_q  <= mask_d;
            rdata_q <= rdata_d;
        end
    end

    // per-source gating
    pieme_gate u_gate (
        .ref_clk_i (ref_clk_i),
        .rstn_i    (rstn_i),
        .en_i      (en),
        .flag_i    (flags),
        .req_o     (irq_req_o)
    );

    // outputs straight from flops
    assign reg_rdata_o = rdata_q;
    assign mask_o      = mask_q;

    // request gating, one cycle behind flag and enable
    a_cmp1_rise_gate: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        $past(rstn_i) |-> irq_req_o[PIEME_CMP1_RISE] ==
            $past(cmp1_rise_flag_i & cmp1_rise_irq_en))
        else $error("comparator 1 rise request does not follow bit 7");

    a_cmp1_rise_block: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        !cmp1_rise_irq_en |=> !irq_req_o[PIEME_CMP1_RISE])
        else $error("comparator 1 rise request passed while bit 7 clear");

    a_cmp1_rise_pass: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (cmp1_rise_irq_en & cmp1_rise_flag_i) |=> irq_req_o[PIEME_CMP1_RISE])
        else $error("comparator 1 rise request lost while bit 7 set");

    a_cmp1_fall_gate: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        !mask_q[PIEME_CMP1_FALL] |=> !irq_req_o[PIEME_CMP1_FALL])
        else $error("comparator 1 fall request passed while bit 6 clear");

    a_cmp1_fall_pass: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (mask_q[PIEME_CMP1_FALL] & cmp1_fall_flag_i) |=> irq_req_o[PIEME_CMP1_FALL])
        else $error("comparator 1 fall request lost while bit 6 set");

    a_cmp1_fall_follow: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        $past(rstn_i) |-> irq_req_o[PIEME_CMP1_FALL] ==
            $past(cmp1_fall_flag_i & cmp1_fall_irq_en))
        else $error("comparator 1 fall request does not follow bit 6");

    a_counter_group: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        $past(rstn_i) |-> irq_req_o[PIEME_CNT_ARRAY] ==
            $past((|counter_array_flag_i) & mask_q[PIEME_CNT_ARRAY]))
        else $error("counter array request does not follow bit 3");

    a_counter_block: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        !counter_array_irq_en |=> !irq_req_o[PIEME_CNT_ARRAY])
        else $error("counter array request passed while bit 3 clear");

    a_counter_any: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (counter_array_irq_en && counter_array_flag_i != 5'h00) |=> irq_req_o[PIEME_CNT_ARRAY])
        else $error("counter array request lost while bit 3 set");

    a_counter_none: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (counter_array_flag_i == 5'h00) |=> !irq_req_o[PIEME_CNT_ARRAY])
        else $error("counter array request without any counter flag");

    a_smbus_gate: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        $past(rstn_i) |-> irq_req_o[PIEME_SMBUS_PORT] ==
            $past(smbus_port_flag_i & mask_q[PIEME_SMBUS_PORT]))
        else $error("smbus request does not follow bit 1");

    a_smbus_block: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        !smbus_port_irq_en |=> !irq_req_o[PIEME_SMBUS_PORT])
        else $error("smbus request passed while bit 1 clear");

    a_smbus_pass: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (smbus_port_irq_en & smbus_port_flag_i) |=> irq_req_o[PIEME_SMBUS_PORT])
        else $error("smbus request lost while bit 1 set");

    a_other_gates: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        $past(rstn_i) |-> {irq_req_o[5], irq_req_o[4], irq_req_o[2], irq_req_o[0]} ==
            $past({cmp0_rise_flag_i & mask_q[5], cmp0_fall_flag_i & mask_q[4],
                   converter_window_flag_i & mask_q[2], spi_port_flag_i & mask_q[0]}))
        else $error("bit 5, 4, 2 or 0 gating wrong");

    a_cmp0_rise_gate: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        $past(rstn_i) |-> irq_req_o[PIEME_CMP0_RISE] ==
            $past(cmp0_rise_flag_i & cmp0_rise_irq_en))
        else $error("comparator 0 rise request does not follow bit 5");

    a_cmp0_fall_gate: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        $past(rstn_i) |-> irq_req_o[PIEME_CMP0_FALL] ==
            $past(cmp0_fall_flag_i & cmp0_fall_irq_en))
        else $error("comparator 0 fall request does not follow bit 4");

    a_window_gate: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        $past(rstn_i) |-> irq_req_o[PIEME_CONV_WIN] ==
            $past(converter_window_flag_i & converter_window_irq_en))
        else $error("window request does not follow bit 2");

    a_spi_gate: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        $past(rstn_i) |-> irq_req_o[PIEME_SPI_PORT] ==
            $past(spi_port_flag_i & spi_port_irq_en))
        else $error("spi request does not follow bit 0");

    a_no_flag_quiet: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (flags == '0) |=> (irq_req_o == '0))
        else $error("request raised with no source flag");

    // register access
    a_mask_write: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (reg_wr_i && reg_addr_i == PIEME_MASK_ADDR) ##1 (reg_rd_i && !reg_wr_i
            && reg_addr_i == PIEME_MASK_ADDR) |=> reg_rdata_o == $past(reg_wdata_i, 2))
        else $error("mask readback differs from written value");

    a_mask_load: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        wr_mask |=> mask_o == $past(reg_wdata_i))
        else $error("mask not loaded by write");

    a_mask_hold: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        !wr_mask |=> $stable(mask_o))
        else $error("mask changed without a write");

    a_unmapped_write: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (reg_wr_i && !sel_mask) |=> $stable(mask_o))
        else $error("write to another address changed the mask");

    a_mask_read: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        rd_mask |=> reg_rdata_o == $past(mask_o))
        else $error("read of the mask returned a wrong value");

    a_write_over_read: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (wr_mask && rd_mask) |=> reg_rdata_o == $past(mask_o))
        else $error("read with write in one cycle did not show the old mask");

    a_unmapped_read: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (reg_addr_i != PIEME_MASK_ADDR) |=> reg_rdata_o == 8'h00)
        else $error("unmapped read returned nonzero");

    a_read_one_cycle: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        !reg_rd_i |=> reg_rdata_o == 8'h00)
        else $error("read data stood longer than one cycle");

    a_mask_reset: assert property (@(posedge ref_clk_i)
        !rstn_i |=> (mask_o == PIEME_MASK_RESET && irq_req_o == '0 && reg_rdata_o == 8'h00))
        else $error("mask, requests or read data not cleared by reset");
endmodule

// file: design/pieme_pkg.sv
// package: register address, bit positions and reset value of the peripheral interrupt mask
package pieme_pkg;
    localparam logic [7:0] PIEME_MASK_ADDR   = 8'he6;
    localparam logic [7:0] PIEME_MASK_RESET  = 8'h00;
    localparam int         PIEME_NUM_SRC     = 8;
    localparam int         PIEME_CMP1_RISE   = 7;
    localparam int         PIEME_CMP1_FALL   = 6;
    localparam int         PIEME_CMP0_RISE   = 5;
    localparam int         PIEME_CMP0_FALL   = 4;
    localparam int         PIEME_CNT_ARRAY   = 3;
    localparam int         PIEME_CONV_WIN    = 2;
    localparam int         PIEME_SMBUS_PORT  = 1;
    localparam int         PIEME_SPI_PORT    = 0;
endpackage

// file: design/pieme_gate.sv
// per-source gate: passes a peripheral flag only while its enable bit is set
`timescale 1ns/1ns
module pieme_gate
    import pieme_pkg::*;
(
    // clock and reset
    input  wire logic                     ref_clk_i,
    input  wire logic                     rstn_i,
    // enables and flags
    input  wire logic [PIEME_NUM_SRC-1:0] en_i,
    input  wire logic [PIEME_NUM_SRC-1:0] flag_i,
    // gated requests
    output logic      [PIEME_NUM_SRC-1:0] req_o
);
    logic [PIEME_NUM_SRC-1:0] req_d;
    logic [PIEME_NUM_SRC-1:0] req_q;

    genvar g;
    generate
        for (g = 0; g < PIEME_NUM_SRC; g = g + 1) begin : g_src
            assign req_d[g] = flag_i[g] & en_i[g];
        end
    endgenerate

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            req_q <= '0;
        end else begin
            req_q <= req_d;
        end
    end

    assign req_o = req_q;
endmodule

// file: sim/pieme_flag_src.sv
// partner model: peripheral flag sources driving level flags
`timescale 1ns/1ns
module pieme_flag_src (
    // flag pattern from the bench
    input  wire logic [11:0] pat_i,
    // level flags toward the mask
    output logic      [11:0] flag_o
);
    assign flag_o = pat_i;
endmodule

// file: sim/testbench.sv
// bench: mask register access and request gating
`timescale 1ns/1ns
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_errors++; \
    $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module testbench;
    import pieme_pkg::*;
    logic        ref_clk_i = 0, rstn_i = 0, wr = 0, rd = 0;
    logic [7:0]  addr = 8'h00, wd = 8'h00, rdata, irq, mask, rq;
    logic [11:0] pat = 12'h000, fl;
    int          n_errors = 0, comparisons = 0, cyc = 0;
    logic [27:0] rows [16] = '{28'h80_800_80, 28'h7f_800_00, 28'h40_400_40, 28'hbf_400_00,
        28'h08_080_08, 28'h08_018_08, 28'hf7_0f8_00, 28'h02_002_02, 28'hfd_002_00,
        28'h30_300_30, 28'h05_005_05, 28'hff_fff_ff, 28'hff_000_00,
        28'h08_020_08, 28'h08_040_08, 28'h0f_f07_07};
    pieme_flag_src src (.pat_i(pat), .flag_o(fl));
    pieme_top uut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .reg_addr_i(addr), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_wdata_i(wd), .reg_rdata_o(rdata), .cmp1_rise_flag_i(fl[11]),
        .cmp1_fall_flag_i(fl[10]), .cmp0_rise_flag_i(fl[9]), .cmp0_fall_flag_i(fl[8]),
        .counter_array_flag_i(fl[7:3]), .converter_window_flag_i(fl[2]),
        .smbus_port_flag_i(fl[1]), .spi_port_flag_i(fl[0]), .irq_req_o(irq), .mask_o(mask));
    initial begin
        forever #10 ref_clk_i = ~ref_clk_i;
    end
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        addr = a;
        wd = d;
        wr = w;
        rd = !w;
        @(posedge ref_clk_i);
        #2;
        q = rdata;
        wr = 1'h0;
        rd = 1'h0;
        @(posedge ref_clk_i);
        #2;
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 2000) begin
            n_errors++;
            print_verdict();
        end
    end
    initial begin
        repeat (12) @(posedge ref_clk_i);
        #2;
        rstn_i = 1'h1;
        `CHK(mask, PIEME_MASK_RESET)
        `CHK(irq, 8'h00)
        acc(1'h0, PIEME_MASK_ADDR, 8'h00, rq);
        `CHK(rq, PIEME_MASK_RESET)
        $display("reset test done");
        foreach (rows[i]) begin
            acc(1'h1, PIEME_MASK_ADDR, rows[i][27:20], rq);
            pat = rows[i][19:8];
            repeat (2) @(posedge ref_clk_i);
            #2;
            `CHK(irq, rows[i][7:0])
            `CHK(mask, rows[i][27:20])
            acc(1'h0, PIEME_MASK_ADDR, 8'h00, rq);
            `CHK(rq, rows[i][27:20])
        end
        $display("table test done");
        addr = PIEME_MASK_ADDR;
        wd = 8'h5a;
        wr = 1'h1;
        @(posedge ref_clk_i);
        #2;
        wr = 1'h0;
        rd = 1'h1;
        @(posedge ref_clk_i);
        #2;
        `CHK(rdata, 8'h5a)
        wd = 8'ha5;
        wr = 1'h1;
        @(posedge ref_clk_i);
        #2;
        `CHK(rdata, 8'h5a)
        `CHK(mask, 8'ha5)
        wr = 1'h0;
        rd = 1'h0;
        @(posedge ref_clk_i);
        #2;
        `CHK(rdata, 8'h00)
        $display("back to back test done");
        acc(1'h1, 8'he7, 8'h00, rq);
        acc(1'h0, 8'he7, 8'h00, rq);
        `CHK(rq, 8'h00)
        `CHK(mask, 8'ha5)
        pat = 12'h800;
        rstn_i = 1'h0;
        @(posedge ref_clk_i);
        #2;
        rstn_i = 1'h1;
        `CHK(mask, PIEME_MASK_RESET)
        @(posedge ref_clk_i);
        #2;
        `CHK(irq, 8'h00)
        acc(1'h1, PIEME_MASK_ADDR, 8'h80, rq);
        @(posedge ref_clk_i);
        #2;
        `CHK(irq, 8'h80)
        $display("unmapped and reset test done");
        print_verdict();
    end
endmodule
